// [core/qpt_slave.sv]
`timescale 1ns/1ns
// Functional notes
// - stop ends transaction, read returns to standby
// - transmitter releases, receiver acks ninth clock
// - ack only matching type and strap bits
// - address lsb one reads, zero writes
// - write mode acks every received byte
// - read sends bytes while master acknowledges
// - nonvolatile write busy, commands ignored
// - polling gets ack only when idle
// - four channels, wiper plus four stored
// - stored register access also loads wiper
// - selection register at seven, resets zero
// - selection bits nv, index low, high
// - nv select zero targets wiper register
// - selection first, then address picks channel
// - address 0-3 channels, 7 selection
// - byte write three bytes then stop
// - programming needs write enable, sda released
// - start precedes every command
// - bytes travel most significant bit first
// - protect pin low blocks stored writes
// - chip select low disables serial side
module qpt_slave
#(
	parameter int         PROG_CYCLES = qpt_pkg::PROG_CYCLES,
	parameter logic [3:0] TYPE_ID     = 4'ha // arbitrary device type value
)
(
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            sclIn,
	input  wire logic            sdaIn,
	output logic                 sdaOut,
	output logic                 sdaOe,
	input  wire logic            chipSelN,
	input  wire logic            writeProtN,
	input  wire logic [2:0]      addrStrapBits,
	output logic [3:0][7:0]      wiperPos,
	output logic                 nvBusy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		qpt_pkg::qpt_state_t           st;
		logic [7:0]                    shift;
		logic [2:0]                    bitCnt;
		logic                          rdMode;
		logic [2:0]                    ptr;
		logic [2:0]                    sel;
		logic [3:0][7:0]               wiper;
		logic [15:0][7:0]              stored;
		logic                          nvPend;
		logic [3:0]                    nvAddr;
		logic [7:0]                    nvData;
		logic                          sdaLow;
		logic                          recalled;
	} qpt_core_t;

	qpt_core_t stQ;
	qpt_core_t stD;
	logic      progStart;
	logic      progBusy;

	qpt_cond_if cond ();

	qpt_cond_det uDet
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.cond    (cond.det)
	);

	qpt_prog_timer #(.PROG_CYCLES(PROG_CYCLES)) uTimer
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.progStart (progStart),
		.progBusy  (progBusy)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// stored array index: channel on top, data index below
	function automatic logic [3:0] storeIdx(input logic [2:0] chan, input logic [2:0] sel);
		storeIdx = {chan[1:0], sel[qpt_pkg::SEL_IDX_HI_BIT], sel[qpt_pkg::SEL_IDX_LO_BIT]};
	endfunction : storeIdx

	function automatic logic [7:0] readValue(input qpt_core_t s);
		if (s.ptr == qpt_pkg::REG_SELECT_ADDR)
			readValue = {5'h00, s.sel};
		else if (s.ptr > qpt_pkg::CHAN_LAST)
			readValue = 8'h00;
		else if (s.sel[qpt_pkg::SEL_NV_BIT])
			readValue = s.stored[storeIdx(s.ptr, s.sel)];
		else
			readValue = s.wiper[s.ptr[1:0]];
	endfunction : readValue

	// load next byte to send and drive its first bit
	function automatic qpt_core_t loadTx(input qpt_core_t s);
		qpt_core_t r;
		logic [7:0] rb;
		r        = s;
		rb       = readValue(s);
		r.sdaLow = ~rb[7];
		r.shift  = {rb[6:0], 1'b0};
		r.bitCnt = 3'h1;
		r.st     = qpt_pkg::ST_TX;
		if (s.ptr <= qpt_pkg::CHAN_LAST && s.sel[qpt_pkg::SEL_NV_BIT])
			r.wiper[s.ptr[1:0]] = rb;
		loadTx = r;
	endfunction : loadTx

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] nb;
		nb  = {stQ.shift[6:0], cond.sdaBit};
		stD = stQ;
		progStart = 1'b0;

		// stored page zero drives the wipers once after reset
		if (!stQ.recalled)
		begin
			for (int i = 0; i < qpt_pkg::NUM_CHAN; i++)
				stD.wiper[i] = stQ.stored[qpt_pkg::NUM_PAGES * i];
			stD.recalled = 1'b1;
		end

		if (!chipSelN)
		begin
			// serial side asleep while the pin interface owns the part
			stD.st     = qpt_pkg::ST_IDLE;
			stD.sdaLow = 1'b0;
		end
		else if (cond.startSeen)
		begin
			stD.st     = qpt_pkg::ST_DEV;
			stD.bitCnt = 3'h0;
			stD.sdaLow = 1'b0;
			stD.nvPend = 1'b0;
		end
		else if (cond.stopSeen)
		begin
			stD.st     = qpt_pkg::ST_IDLE;
			stD.sdaLow = 1'b0;
			stD.nvPend = 1'b0;
			if (stQ.nvPend && writeProtN)
			begin
				stD.stored[stQ.nvAddr] = stQ.nvData;
				progStart              = 1'b1;
			end
		end
		else
		begin
			case (stQ.st)
				qpt_pkg::ST_DEV, qpt_pkg::ST_REG, qpt_pkg::ST_DATA:
				begin
					if (cond.sclRise)
					begin
						stD.shift  = nb;
						stD.bitCnt = stQ.bitCnt + 3'h1;
						if (stQ.bitCnt == 3'h7)
						begin
							case (stQ.st)
								qpt_pkg::ST_DEV:
								begin
									// a busy part stays silent, so polling sees no ack
									if (nb[qpt_pkg::ADDR_TYPE_MSB:qpt_pkg::ADDR_TYPE_LSB] == TYPE_ID
										&& nb[qpt_pkg::ADDR_STRAP_MSB:qpt_pkg::ADDR_STRAP_LSB]
										== addrStrapBits
										&& !progBusy)
									begin
										stD.rdMode = nb[qpt_pkg::ADDR_DIR_BIT];
										stD.st     = qpt_pkg::ST_DEV_ACK;
									end
									else
										stD.st = qpt_pkg::ST_IDLE;
								end
								qpt_pkg::ST_REG:
								begin
									stD.ptr = nb[2:0];
									stD.st  = qpt_pkg::ST_REG_ACK;
								end
								default:
								begin
									if (stQ.ptr == qpt_pkg::REG_SELECT_ADDR)
										stD.sel = nb[2:0];
									else if (stQ.ptr <= qpt_pkg::CHAN_LAST)
									begin
										stD.wiper[stQ.ptr[1:0]] = nb;
										if (stQ.sel[qpt_pkg::SEL_NV_BIT])
										begin
											stD.nvPend = 1'b1;
											stD.nvAddr = storeIdx(stQ.ptr, stQ.sel);
											stD.nvData = nb;
										end
									end
									stD.st = qpt_pkg::ST_DATA_ACK;
								end
							endcase
						end
					end
				end
				qpt_pkg::ST_DEV_ACK, qpt_pkg::ST_REG_ACK, qpt_pkg::ST_DATA_ACK:
				begin
					if (cond.sclFall)
					begin
						if (!stQ.sdaLow)
							stD.sdaLow = 1'b1;
						else
						begin
							stD.sdaLow = 1'b0;
							stD.bitCnt = 3'h0;
							if (stQ.st == qpt_pkg::ST_DEV_ACK && stQ.rdMode)
								stD = loadTx(stD);
							else if (stQ.st == qpt_pkg::ST_DEV_ACK)
								stD.st = qpt_pkg::ST_REG;
							else
								stD.st = qpt_pkg::ST_DATA;
						end
					end
				end
				qpt_pkg::ST_TX:
				begin
					if (cond.sclFall)
					begin
						if (stQ.bitCnt == 3'h0)
						begin
							stD.sdaLow = 1'b0;
							stD.st     = qpt_pkg::ST_TX_ACK;
						end
						else
						begin
							stD.sdaLow = ~stQ.shift[7];
							stD.shift  = {stQ.shift[6:0], 1'b0};
							stD.bitCnt = stQ.bitCnt + 3'h1;
						end
					end
				end
				qpt_pkg::ST_TX_ACK:
				begin
					// without an ack the slave lets go and waits for stop
					if (cond.sclRise)
						stD.st = cond.sdaBit ? qpt_pkg::ST_IDLE : qpt_pkg::ST_TX_GO;
				end
				qpt_pkg::ST_TX_GO:
				begin
					if (cond.sclFall)
						stD = loadTx(stD);
				end
				default:
				begin
					stD.st     = qpt_pkg::ST_IDLE;
					stD.sdaLow = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stQ          <= '0;
			stQ.st       <= qpt_pkg::ST_IDLE;
			stQ.sel      <= qpt_pkg::SEL_RESET[2:0];
			stQ.recalled <= 1'b0;
		end
		else
			stQ <= stD;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// only ever pull low; the pull-up supplies the high level
	assign sdaOut   = 1'b0;
	assign sdaOe    = stQ.sdaLow;
	assign wiperPos = stQ.wiper;
	assign nvBusy   = progBusy;

endmodule : qpt_slave

module qpt_prog_timer
#(
	parameter int PROG_CYCLES = qpt_pkg::PROG_CYCLES
)
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic progStart,
	output logic      progBusy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [qpt_pkg::BUSY_W-1:0] cnt;
	} qpt_timer_t;

	localparam logic [qpt_pkg::BUSY_W-1:0] PROG_LOAD = PROG_CYCLES[qpt_pkg::BUSY_W-1:0];

	qpt_timer_t stQ;
	qpt_timer_t stD;

	// a new store restarts the count, so the load wins over the decrement
	always_comb
	begin
		stD = stQ;
		if (stQ.cnt != '0)
			stD.cnt = stQ.cnt - 1'b1;
		if (progStart)
			stD.cnt = PROG_LOAD;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stQ <= '0;
		else
			stQ <= stD;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// counter width covers the default store time at this clock, not much more
	assign progBusy = (stQ.cnt != '0);

endmodule : qpt_prog_timer

// [core/qpt_pkg.sv]
package qpt_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_SELECT_ADDR = 3'h7;
	localparam logic [2:0] CHAN_LAST       = 3'h3;
	localparam logic [7:0] SEL_RESET       = 8'h00;
	localparam int         SEL_NV_BIT      = 0;
	localparam int         SEL_IDX_LO_BIT  = 1;
	localparam int         SEL_IDX_HI_BIT  = 2;
	localparam int         NUM_CHAN        = 4;
	localparam int         NUM_PAGES       = 4;

	// ----------------------------------------------------------------
	// slave address layout
	// ----------------------------------------------------------------
	localparam int         ADDR_DIR_BIT    = 0;
	localparam int         ADDR_STRAP_LSB  = 1;
	localparam int         ADDR_STRAP_MSB  = 3;
	localparam int         ADDR_TYPE_LSB   = 4;
	localparam int         ADDR_TYPE_MSB   = 7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_FREQ_KHZ    = 10000;
	localparam int         PROG_TIME_US    = 5000;
	localparam int         PROG_CYCLES     = (PROG_TIME_US * CLK_FREQ_KHZ) / 1000;
	localparam int         BUSY_W          = 16;

	// ----------------------------------------------------------------
	// protocol states
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_IDLE,
		ST_DEV,
		ST_DEV_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_DATA,
		ST_DATA_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_TX_GO
	} qpt_state_t;

endpackage : qpt_pkg

// [core/qpt_cond_if.sv]
`timescale 1ns/1ns
interface qpt_cond_if;
	logic startSeen;
	logic stopSeen;
	logic sclRise;
	logic sclFall;
	logic sdaBit;

	modport det
	(
		output startSeen,
		output stopSeen,
		output sclRise,
		output sclFall,
		output sdaBit
	);

	modport ctrl
	(
		input startSeen,
		input stopSeen,
		input sclRise,
		input sclFall,
		input sdaBit
	);
endinterface : qpt_cond_if

// [core/qpt_cond_det.sv]
`timescale 1ns/1ns
module qpt_cond_det
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	qpt_cond_if.det   cond
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic scl;
		logic sda;
	} qpt_det_t;

	qpt_det_t stQ;
	qpt_det_t stD;

	always_comb
	begin
		stD     = stQ;
		stD.scl = sclIn;
		stD.sda = sdaIn;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stQ <= '{scl: 1'b1, sda: 1'b1};
		else
			stQ <= stD;
	end

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	// sda moving while scl stays high marks frame boundaries
	assign cond.startSeen = stQ.scl & sclIn & stQ.sda & ~sdaIn;
	assign cond.stopSeen  = stQ.scl & sclIn & ~stQ.sda & sdaIn;
	assign cond.sclRise   = ~stQ.scl & sclIn;
	assign cond.sclFall   = stQ.scl & ~sclIn;
	assign cond.sdaBit    = sdaIn;

endmodule : qpt_cond_det

// [tb/qpt_checker.sv]
`timescale 1ns/1ns
module qpt_checker
#(
	parameter int PROG_CYCLES = 20
)
(
	input wire logic            sys_clk,
	input wire logic            rst_n,
	input wire logic            sclIn,
	input wire logic            sdaIn,
	input wire logic            sdaOut,
	input wire logic            sdaOe,
	input wire logic            chipSelN,
	input wire logic            writeProtN,
	input wire logic [3:0][7:0] wiperPos,
	input wire logic            nvBusy
);
	// ----
	// busy count: too long for a repetition
	// ----
	logic [15:0] busyCnt_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			busyCnt_q <= 16'h0000;
		else
			busyCnt_q <= nvBusy ? busyCnt_q + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	open_drain_a : assert property (sdaOut == 1'b0)
		else $error("sda value high");
	busy_min_a : assert property ($rose(nvBusy) |-> nvBusy[*8])
		else $error("busy short");
	busy_len_a : assert property ($fell(nvBusy) |-> busyCnt_q == PROG_CYCLES)
		else $error("busy length");
	busy_cause_a : assert property ($rose(nvBusy) |-> sclIn && sdaIn && writeProtN)
		else $error("busy without stop");
	busy_quiet_a : assert property (nvBusy |-> !sdaOe)
		else $error("answer while busy");
	store_protect_a : assert property (!writeProtN && !nvBusy |=> !nvBusy)
		else $error("protected store");
	deselect_quiet_a : assert property ((!chipSelN)[*2] |-> !sdaOe)
		else $error("answer deselected");
	wiper_hold_a : assert property (!chipSelN |=> $stable(wiperPos))
		else $error("wiper moved");
	scl_low_a : assert property (chipSelN && $changed(sdaOe) |-> !sclIn)
		else $error("sda moved scl high");
endmodule : qpt_checker

bind qpt_slave qpt_checker #(.PROG_CYCLES(PROG_CYCLES)) i_qpt_checker
(
	.sys_clk   (sys_clk),
	.rst_n     (rst_n),
	.sclIn     (sclIn),
	.sdaIn     (sdaIn),
	.sdaOut    (sdaOut),
	.sdaOe     (sdaOe),
	.chipSelN  (chipSelN),
	.writeProtN(writeProtN),
	.wiperPos  (wiperPos),
	.nvBusy    (nvBusy)
);

// [tb/qpt_mst.sv]
`timescale 1ns/1ns
module qpt_mst
(
	input  wire logic sys_clk,
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaPull
);
	// ----
	// bus master: 8 clocks a bit, scl idles high
	// ----
	logic seenBit;
	initial
	begin
		sclOut  = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// data moves only mid-way through scl low
	task automatic clock_bit(input logic pull);
		sclOut <= 1'b0;
		tick(2);
		sdaPull <= pull;
		tick(2);
		sclOut <= 1'b1;
		tick(2);
		seenBit = sdaLine;
		tick(2);
	endtask : clock_bit
	task automatic frame_edge(input logic isStop);
		clock_bit(isStop);
		sdaPull <= ~isStop;
		tick(4);
	endtask : frame_edge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
			clock_bit(~b[i]);
		clock_bit(1'b0);
		ack = ~seenBit;
	endtask : send_byte
	task automatic get_byte(input logic ackIt, output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			clock_bit(1'b0);
			b[i] = seenBit;
		end
		clock_bit(ackIt);
	endtask : get_byte
endmodule : qpt_mst

// [tb/qpt_slave_tb.sv]
`timescale 1ns/1ns
module qpt_slave_tb;
	localparam int         PROG     = 200;
	localparam logic [3:0] DEV_TYPE = 4'ha; // arbitrary type value
	logic            sys_clk;
	logic            rst_n;
	logic            sclIn;
	logic            sdaPull;
	logic            sdaOut;
	logic            sdaOe;
	logic            chipSelN;
	logic            writeProtN;
	logic [2:0]      strap;
	logic [3:0][7:0] wiperPos;
	logic            nvBusy;
	logic [7:0]      val;
	integer          seed;
	int              badCount;
	int              compares;
	// pull-up wins unless someone pulls low
	wire             sdaLine = ~((sdaOe & ~sdaOut) | sdaPull);
	qpt_slave #(.PROG_CYCLES(PROG), .TYPE_ID(DEV_TYPE)) i_qpt_slave
	(
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.sclIn        (sclIn),
		.sdaIn        (sdaLine),
		.sdaOut       (sdaOut),
		.sdaOe        (sdaOe),
		.chipSelN     (chipSelN),
		.writeProtN   (writeProtN),
		.addrStrapBits(strap),
		.wiperPos     (wiperPos),
		.nvBusy       (nvBusy)
	);
	qpt_mst i_qpt_mst (.sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclIn), .sdaPull(sdaPull));
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	function automatic logic [7:0] addr_byte(input logic rd);
		return {DEV_TYPE, strap, rd};
	endfunction : addr_byte
	function automatic logic [7:0] sel_view(input logic [7:0] w);
		return {5'h00, w[2:0]};
	endfunction : sel_view
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			badCount++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic probe(input logic [7:0] dev, input logic exp);
		logic       a;
		logic [7:0] b;
		i_qpt_mst.frame_edge(1'b0);
		i_qpt_mst.send_byte(dev, a);
		check_byte({7'h00, a}, {7'h00, exp});
		if (a === 1'b1 && dev[0] === 1'b1)
			i_qpt_mst.get_byte(1'b0, b);
		i_qpt_mst.frame_edge(1'b1);
	endtask : probe
	task automatic pick(input logic [2:0] regAddr);
		logic a;
		i_qpt_mst.frame_edge(1'b0);
		i_qpt_mst.send_byte(addr_byte(1'b0), a);
		check_byte({7'h00, a}, 8'h01);
		i_qpt_mst.send_byte({5'h00, regAddr}, a);
		check_byte({7'h00, a}, 8'h01);
	endtask : pick
	task automatic write_reg(input logic [2:0] regAddr, input logic [7:0] d);
		logic a;
		pick(regAddr);
		i_qpt_mst.send_byte(d, a);
		check_byte({7'h00, a}, 8'h01);
		i_qpt_mst.frame_edge(1'b1);
	endtask : write_reg
	task automatic read_reg(input logic [2:0] regAddr, input logic [7:0] exp);
		logic       a;
		logic [7:0] b;
		pick(regAddr);
		i_qpt_mst.frame_edge(1'b0);
		i_qpt_mst.send_byte(addr_byte(1'b1), a);
		check_byte({7'h00, a}, 8'h01);
		i_qpt_mst.get_byte(1'b1, b);
		check_byte(b, exp);
		i_qpt_mst.get_byte(1'b0, b);
		check_byte(b, exp);
		i_qpt_mst.frame_edge(1'b1);
	endtask : read_reg
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		seed = 13;
		badCount = 0;
		compares = 0;
		rst_n = 1'b0;
		chipSelN = 1'b1;
		writeProtN = 1'b1;
		strap = 3'h0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		strap <= 3'($random(seed));
		repeat (2) @(posedge sys_clk);
		for (int c = 0; c < 4; c++)
			check_byte(wiperPos[c], 8'h00);
		read_reg(3'h7, 8'h00);
		for (int n = 0; n < 6; n++)
		begin
			val = 8'($random(seed));
			val[7] = (val[7:1] == {DEV_TYPE, strap}) ? ~val[7] : val[7];
			probe(val, 1'b0);
		end
		probe({DEV_TYPE, strap ^ 3'h4, 1'b1}, 1'b0);
		probe(addr_byte(1'b1), 1'b1);
		$display("test address ended");
		write_reg(3'h7, 8'h06);
		read_reg(3'h7, sel_view(8'h06));
		for (int c = 0; c < 4; c++)
		begin
			val = 8'($random(seed));
			write_reg(3'(c), val);
			check_byte(wiperPos[c], val);
			read_reg(3'(c), val);
		end
		read_reg(3'h5, 8'h00);
		$display("test wiper ended");
		write_reg(3'h7, 8'h03);
		write_reg(3'h2, 8'h3a);
		check_byte({7'h00, nvBusy}, 8'h01);
		check_byte(wiperPos[2], 8'h3a);
		probe(addr_byte(1'b0), 1'b0);
		repeat (PROG)
			if (nvBusy === 1'b1)
				@(posedge sys_clk);
		if (nvBusy !== 1'b0)
		begin
			$display("MISMATCH %0t busy wait ran out", $time);
			badCount++;
		end
		probe(addr_byte(1'b1), 1'b1);
		write_reg(3'h7, 8'h00);
		write_reg(3'h2, 8'h55);
		check_byte(wiperPos[2], 8'h55);
		check_byte({7'h00, nvBusy}, 8'h00);
		write_reg(3'h7, 8'h03);
		read_reg(3'h2, 8'h3a);
		check_byte(wiperPos[2], 8'h3a);
		$display("test store ended");
		writeProtN <= 1'b0;
		write_reg(3'h3, 8'ha5);
		check_byte({7'h00, nvBusy}, 8'h00);
		check_byte(wiperPos[3], 8'ha5);
		read_reg(3'h3, 8'h00);
		writeProtN <= 1'b1;
		chipSelN <= 1'b0;
		probe(addr_byte(1'b0), 1'b0);
		chipSelN <= 1'b1;
		$display("test protect ended");
		rst_n <= 1'b0;
		strap <= strap ^ 3'h5;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (int c = 0; c < 4; c++)
			check_byte(wiperPos[c], 8'h00);
		read_reg(3'h7, 8'h00);
		probe({DEV_TYPE, strap ^ 3'h5, 1'b0}, 1'b0);
		probe(addr_byte(1'b0), 1'b1);
		$display("test reset ended");
		give_verdict();
	end
endmodule : qpt_slave_tb
